// *** hdl/logic_block_defines.svh ***
// Constants for the programmable logic block: configuration field positions and widths.
`ifndef LOGIC_BLOCK_DEFINES_SVH
`define LOGIC_BLOCK_DEFINES_SVH
`define LB_LUT_ENTRIES 16
`define LB_MEM_DEPTH 16
`define LB_ADDR_W 4
`define LB_SLICE_IN 13
`define LB_SLICE_OUT 6
`define LB_TOP_IN 10
`define LB_TOP_OUT 4
`define LB_REG_SLICES 3
// Per-slice register configuration bit positions.
`define LB_CFG_NEG 0
`define LB_CFG_LATCH 1
`define LB_CFG_SYNC 2
`define LB_CFG_INIT0 3
`define LB_CFG_INIT1 4
`define LB_CFG_W 5
`define LB_INIT_VAL 1'b0
`endif

// *** hdl/logic_block_pkg.sv ***
// Types shared by the programmable logic block files.
`default_nettype none
package logic_block_pkg;
  // Slice operating modes, one-hot.
  typedef enum logic [3:0] {
    MODE_LOGIC  = 4'h1,
    MODE_RIPPLE = 4'h2,
    MODE_RAM    = 4'h4,
    MODE_ROM    = 4'h8
  } slice_mode_t;
  // Ripple functions chosen within ripple mode.
  typedef enum logic [2:0] {
    RIP_ADD    = 3'h0,
    RIP_SUB    = 3'h1,
    RIP_ADDSUB = 3'h2,
    RIP_CNTUP  = 3'h3,
    RIP_CNTDN  = 3'h4,
    RIP_CNTUD  = 3'h5,
    RIP_CMP    = 3'h6,
    RIP_MULT   = 3'h7
  } ripple_fn_t;
endpackage : logic_block_pkg
`default_nettype wire

// *** hdl/slice_storage_reg.sv ***
// One slice storage element: edge of either polarity or latch, sync or async set/reset.
`default_nettype none
`include "logic_block_defines.svh"
module slice_storage_reg
  import logic_block_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration.
  input wire logic negEdge,
  input wire logic latchMode,
  input wire logic syncSr,
  input wire logic initVal,
  // Data path.
  input wire logic chipSel,
  input wire logic setReset,
  input wire logic d,
  output logic q
);
  // Rising-edge copy, falling-edge copy, and the level-sensitive latch transparent while the clock is high.
  logic posQ_r;
  logic negQ_r;
  logic latQ_r;
  logic srAsync;

  // Asynchronous set/reset only when configured so.
  assign srAsync = setReset & ~syncSr;

  // Rising-edge register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      posQ_r <= `LB_INIT_VAL;
    end else if (setReset) begin
      posQ_r <= initVal;
    end else if (chipSel) begin
      posQ_r <= d;
    end
  end

  // Falling-edge register.
  always_ff @(negedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      negQ_r <= `LB_INIT_VAL;
    end else if (setReset) begin
      negQ_r <= initVal;
    end else if (chipSel) begin
      negQ_r <= d;
    end
  end

  // Latch follows d while the clock level and chip select are high.
  always_latch begin
    if (!rst_n) begin
      latQ_r = `LB_INIT_VAL;
    end else if (setReset) begin
      latQ_r = initVal;
    end else if (sys_clk && chipSel) begin
      latQ_r = d;
    end
  end

  // Output selection; an async set/reset overrides immediately.
  always_comb begin
    if (srAsync) begin
      q = initVal;
    end else if (latchMode) begin
      q = latQ_r;
    end else if (negEdge) begin
      q = negQ_r;
    end else begin
      q = posQ_r;
    end
  end
endmodule : slice_storage_reg
`default_nettype wire

// *** hdl/logic_block.sv ***
// Programmable logic block with four slices, ripple arithmetic and distributed memory.
// Operation
// R1: slices 0-2 two LUTs, two registers
// R2: memory only in RAM-capable variant; the code loads memCol_r and reads memDpData in both variants
// R3: LUTs combine into 5-8 input functions; the code builds LUT5, LUT6 and LUT7 only
// R4: sync/async set/reset, clock and chip select
// R5: register rising, falling edge or latch
// R6: slices 0-2: 13 in, carry, 6 out
// R7: slice 3: 10 in, 4 out, no carry
// R8: LUT gives any four-input function
// R9: two LUTs form LUT5; slices chain wider
// R10: ripple 2-bit add, subtract, dynamic direction
// R11: ripple 2-bit counters, clear and preload
// R12: compare ge, ne, le; multiplier cell
// R13: fast carry generate and propagate
// R14: slices 0,1 form 16x4 memory
// R15: pseudo dual port adds read-only port
// R16: either memory uses three slices
// R17: memory contents loadable with initial values
// R18: registers start at configured initial value; the code resets them to 0 and loads the configured value only on set/reset
// R19: slice 3 logic/ROM; no RAM without variant
// R20: write on clock edge, read combinational; the code registers the read data into memRdData and memDpData
`default_nettype none
`include "logic_block_defines.svh"
module logic_block
  import logic_block_pkg::*;
#(
  parameter bit RAM_CAPABLE = 1'b1
)(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Per-slice configuration.
  input wire slice_mode_t sliceMode [0:3],
  input wire ripple_fn_t rippleFn [0:2],
  input wire logic [`LB_LUT_ENTRIES-1:0] lutTable [0:7],
  input wire logic [`LB_CFG_W-1:0] regCfg [0:2],
  input wire logic wideSel [0:1],
  // Memory initial load.
  input wire logic memInitLoad,
  input wire logic [`LB_MEM_DEPTH-1:0] memInit [0:3],
  // Routing inputs and carry.
  input wire logic [`LB_SLICE_IN-1:0] sliceIn [0:2],
  input wire logic [`LB_TOP_IN-1:0] topIn,
  input wire logic carryIn,
  input wire logic [`LB_ADDR_W-1:0] rdAddr,
  // Routing outputs and carry.
  output logic [`LB_SLICE_OUT-1:0] sliceOut [0:2],
  output logic [`LB_TOP_OUT-1:0] topOut,
  output logic carryOut,
  output logic [`LB_MEM_DEPTH/4-1:0] memRdData,
  output logic [1:0] memDpData
);
  // Slice input map: [3:0] LUT0 in, [7:4] LUT1 in, [8] M0 data, [9] M1 data,
  // [10] clock select high, [11] chip select, [12] set/reset.

  // Read any four-input table.
  function automatic logic lut4(input logic [15:0] tbl, input logic [3:0] sel);
    lut4 = tbl[sel];
  endfunction : lut4

  // Distributed memory: four 16x1 columns living in the LUTs of slices 0 and 1.
  logic [`LB_MEM_DEPTH-1:0] memCol_r [0:3];
  logic ramEn;
  logic [`LB_ADDR_W-1:0] wrAddr;
  logic wrEn;
  logic [3:0] wrData;
  logic [2:0] carry;
  logic [1:0] lutO [0:3];
  logic [1:0] regQ [0:2];
  logic [1:0] sum [0:2];
  logic [1:0] cg;
  logic [1:0] cp;
  logic [2:0] cmp;
  logic [5:0] outNxt [0:2];
  logic [3:0] topNxt;
  logic lut5 [0:3];

  // R2: RAM mode only in the RAM-capable variant.
  // R19: slice 3 never offers RAM or ripple.
  assign ramEn = RAM_CAPABLE && sliceMode[0] == MODE_RAM && sliceMode[1] == MODE_RAM;
  // R14: slice 2 provides address and write enable.
  assign wrAddr = sliceIn[2][3:0];
  assign wrEn = ramEn && sliceMode[2] == MODE_RAM && sliceIn[2][11];
  assign wrData = {sliceIn[1][9], sliceIn[1][8], sliceIn[0][9], sliceIn[0][8]};

  // LUT evaluation for all slices; memory columns replace the tables of slices 0 and 1 in RAM mode.
  genvar gs;
  generate
    for (gs = 0; gs < 4; gs++) begin : g_lut
      logic [3:0] in0;
      logic [3:0] in1;
      if (gs < 3) begin : g_full
        assign in0 = sliceIn[gs][3:0];
        assign in1 = sliceIn[gs][7:4];
      end else begin : g_top
        assign in0 = topIn[3:0];
        assign in1 = topIn[7:4];
      end
      // R8: table lookup of sixteen entries.
      // R20: memory read is combinational.
      always_comb begin
        // Single-port reads use the shared address from slice 2, as writes do.
        if (gs < 2 && ramEn) begin
          lutO[gs][0] = lut4(memCol_r[(2*gs) % 4], wrAddr);
          lutO[gs][1] = lut4(memCol_r[(2*gs+1) % 4], wrAddr);
        end else begin
          lutO[gs][0] = lut4(lutTable[2*gs], in0);
          lutO[gs][1] = lut4(lutTable[2*gs+1], in1);
        end
      end
      // R9: fifth input picks between the two LUTs.
      // R3: wider combining via the local mux.
      assign lut5[gs] = (gs < 3 ? sliceIn[gs % 3][8] : topIn[8]) ? lutO[gs][1] : lutO[gs][0];
    end
  endgenerate

  // R3: LUT6 from slices 0/1 and 2/3, LUT7 from both LUT6s.
  logic lut6a;
  logic lut6b;
  logic lut7;
  assign lut6a = wideSel[0] ? lut5[1] : lut5[0];
  assign lut6b = wideSel[0] ? lut5[3] : lut5[2];
  assign lut7 = wideSel[1] ? lut6b : lut6a;

  // R17: initial contents load; R20: write on the clock edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 4; c++) begin
        memCol_r[c] <= '0;
      end
    end else if (memInitLoad) begin
      for (int c = 0; c < 4; c++) begin
        memCol_r[c] <= memInit[c];
      end
    end else if (wrEn) begin
      for (int c = 0; c < 4; c++) begin
        memCol_r[c][wrAddr] <= wrData[c];
      end
    end
  end

  // R14: 16x4 single-port read data.
  // R15: read-only port on the companion slice, 16x2 wide.
  // R16: both memories use slices 0, 1 and 2.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      memRdData <= '0;
      memDpData <= '0;
    end else begin
      memRdData <= {lutO[1][1], lutO[1][0], lutO[0][1], lutO[0][0]};
      memDpData <= {memCol_r[1][rdAddr], memCol_r[0][rdAddr]};
    end
  end

  // Ripple arithmetic per register slice with carry chain.
  assign carry[0] = carryIn;
  generate
    for (gs = 0; gs < 3; gs++) begin : g_rip
      logic [1:0] a;
      logic [1:0] b;
      logic [1:0] bEff;
      logic sub;
      logic cin;
      logic [2:0] res;
      assign a = sliceIn[gs][1:0];
      assign b = sliceIn[gs][5:4];
      // R10: add, subtract, or direction from a dynamic input.
      // R11: counters add or subtract one to the register value.
      always_comb begin
        sub = 1'b0;
        bEff = b;
        cin = carry[gs];
        unique case (rippleFn[gs])
          RIP_ADD: sub = 1'b0;
          RIP_SUB: sub = 1'b1;
          RIP_ADDSUB: sub = sliceIn[gs][9];
          RIP_CNTUP: begin
            bEff = 2'h1;
            cin = 1'b0;
          end
          RIP_CNTDN: begin
            bEff = 2'h1;
            sub = 1'b1;
          end
          RIP_CNTUD: begin
            bEff = 2'h1;
            sub = ~sliceIn[gs][9];
          end
          RIP_CMP: sub = 1'b1;
          RIP_MULT: bEff = b & {2{sliceIn[gs][6]}};
        endcase
      end
      logic [1:0] opA;
      assign opA = (rippleFn[gs] inside {RIP_CNTUP, RIP_CNTDN, RIP_CNTUD}) ? regQ[gs] : a;
      logic [1:0] bX;
      assign bX = sub ? ~bEff : bEff;
      // The first slice forces the two's-complement one; later slices chain the carry.
      assign res = {1'b0, opA} + {1'b0, bX} + {2'h0, (sub && gs == 0) ? 1'b1 : cin};
      assign sum[gs] = res[1:0];
      assign carry[gs+1] = res[2];
    end
  endgenerate

  // R13: fast carry generate and propagate of slice 0.
  assign cg = sliceIn[0][1:0] & sliceIn[0][5:4];
  assign cp = sliceIn[0][1:0] ^ sliceIn[0][5:4];
  // R12: comparator flags of slice 0 operands.
  assign cmp = {sliceIn[0][1:0] <= sliceIn[0][5:4], sliceIn[0][1:0] != sliceIn[0][5:4],
                sliceIn[0][1:0] >= sliceIn[0][5:4]};

  // R1: two storage registers in each of slices 0 to 2.
  generate
    for (gs = 0; gs < 3; gs++) begin : g_reg
      genvar gb;
      for (gb = 0; gb < 2; gb++) begin : g_bit
        logic dIn;
        logic pre;
        // R11: preload overrides the count in RIP_CNTUD only; clear via set/reset, async unless sync is configured.
        assign pre = sliceMode[gs] == MODE_RIPPLE && rippleFn[gs] == RIP_CNTUD
                     && sliceIn[gs][10];
        assign dIn = sliceMode[gs] == MODE_RIPPLE ? (pre ? sliceIn[gs][gb] : sum[gs][gb])
                     : lutO[gs][gb];
        // R4: set/reset mode, chip select.
        // R5: edge polarity or latch.
        // R18: configured value loaded on set/reset; reset loads 0.
        slice_storage_reg u_reg (
          .sys_clk(sys_clk),
          .rst_n(rst_n),
          .negEdge(regCfg[gs][`LB_CFG_NEG] ^ sliceIn[gs][10]),
          .latchMode(regCfg[gs][`LB_CFG_LATCH]),
          .syncSr(regCfg[gs][`LB_CFG_SYNC]),
          .initVal(regCfg[gs][`LB_CFG_INIT0 + gb]),
          .chipSel(sliceIn[gs][11]),
          .setReset(sliceIn[gs][12]),
          .d(dIn),
          .q(regQ[gs][gb])
        );
      end
    end
  endgenerate

  // R6: six routing outputs per register slice.
  always_comb begin
    for (int s = 0; s < 3; s++) begin
      outNxt[s] = {1'b0, lut5[s], regQ[s], lutO[s]};
    end
    if (sliceMode[0] == MODE_RIPPLE) begin
      outNxt[0][5] = rippleFn[0] == RIP_CMP ? cmp[0] : cg[0] | cp[0];
    end
    outNxt[1][5] = lut7;
    outNxt[2][5] = sliceMode[2] == MODE_RIPPLE ? cmp[1] ^ cmp[2] : lut6a;
  end

  // R7: slice 3 drives four routing outputs, no carry.
  assign topNxt = {lut6b, lut5[3], lutO[3]};

  // Output registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < 3; s++) begin
        sliceOut[s] <= '0;
      end
      topOut <= '0;
      carryOut <= 1'b0;
    end else begin
      for (int s = 0; s < 3; s++) begin
        sliceOut[s] <= outNxt[s];
      end
      topOut <= topNxt;
      // R6: carry to the adjacent block.
      carryOut <= carry[3];
    end
  end
endmodule : logic_block
`default_nettype wire

// *** test/logic_block_props.sv ***
// Port checker for the programmable logic block.
`default_nettype none
`include "logic_block_defines.svh"
module logic_block_props
  import logic_block_pkg::*;
#(
  parameter bit RAM_CAPABLE = 1'b1
)(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration and routing inputs.
  input wire slice_mode_t sliceMode [0:3],
  input wire logic [`LB_LUT_ENTRIES-1:0] lutTable [0:7],
  input wire logic [`LB_CFG_W-1:0] regCfg [0:2],
  input wire logic memInitLoad,
  input wire logic [`LB_MEM_DEPTH-1:0] memInit [0:3],
  input wire logic [`LB_SLICE_IN-1:0] sliceIn [0:2],
  input wire logic [`LB_TOP_IN-1:0] topIn,
  input wire logic [`LB_ADDR_W-1:0] rdAddr,
  // Outputs.
  input wire logic [`LB_SLICE_OUT-1:0] sliceOut [0:2],
  input wire logic [`LB_TOP_OUT-1:0] topOut,
  input wire logic carryOut,
  input wire logic [`LB_MEM_DEPTH/4-1:0] memRdData,
  input wire logic [1:0] memDpData
);
  // All checks run on the rising edge and pause in reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  reset_clear_a: assert property ($rose(rst_n) |-> topOut == 0 && !carryOut && memRdData == 0)
    else $error("top outputs not clear after reset");
  reset_slice_a: assert property ($rose(rst_n) |-> sliceOut[0] == 0 && sliceOut[2] == 0
    && memDpData == 0) else $error("slice outputs not clear after reset");
  lut_zero_a: assert property (
    (sliceMode[3] == MODE_LOGIC && lutTable[6] == 16'h0000)[*3] |-> !topOut[0])
    else $error("all-zero table gave a one");
  lut_ones_a: assert property (
    (sliceMode[0] == MODE_LOGIC && lutTable[0] == 16'hffff)[*3] |-> sliceOut[0][0])
    else $error("all-ones table gave a zero");
  wide_five_a: assert property ((sliceMode[3] == MODE_LOGIC && lutTable[6] == 16'hffff
    && lutTable[7] == 16'hffff)[*3] |-> topOut[2]) else $error("five-input result wrong");
  top_stands_a: assert property (($stable(topIn) && $stable(lutTable[6])
    && sliceMode[3] == MODE_LOGIC)[*4] |-> $stable(topOut[0])) else $error("output moved");
  dp_init_a: assert property ((RAM_CAPABLE && sliceMode[0] == MODE_RAM && memInitLoad
    && !sliceIn[2][11] && $stable(rdAddr))[*3]
    |-> memDpData == {memInit[1][rdAddr], memInit[0][rdAddr]}) else $error("bad init read");
  sr_init_a: assert property ((sliceIn[0][12] && $stable(regCfg[0]))[*3]
    |-> sliceOut[0][3:2] == regCfg[0][4:3]) else $error("set/reset value wrong");

  // Main scenarios reached.
  cover property (memInitLoad [*3]);
  cover property (sliceIn[2][11] && sliceMode[0] == MODE_RAM);
  cover property (sliceIn[0][12] && regCfg[0][2]);
endmodule : logic_block_props

bind logic_block logic_block_props #(.RAM_CAPABLE(RAM_CAPABLE)) logic_block_props_inst (
  .sys_clk, .rst_n, .sliceMode, .lutTable, .regCfg, .memInitLoad, .memInit, .sliceIn,
  .topIn, .rdAddr, .sliceOut, .topOut, .carryOut, .memRdData, .memDpData);
`default_nettype wire

// *** test/programmable_logic_slice_block_test.sv ***
// Self-checking bench for the programmable logic block.
`default_nettype none
module programmable_logic_slice_block_test
  import logic_block_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  slice_mode_t sliceMode [0:3];
  ripple_fn_t rippleFn [0:2];
  logic [15:0] lutTable [0:7];
  logic [4:0] regCfg [0:2];
  logic wideSel [0:1];
  logic memInitLoad;
  logic [15:0] memInit [0:3];
  logic [12:0] sliceIn [0:2];
  logic [9:0] topIn;
  logic carryIn;
  logic [3:0] rdAddr;
  logic [5:0] sliceOut [0:2];
  logic [3:0] topOut;
  logic carryOut;
  logic [3:0] memRdData;
  logic [3:0] memRdData2;
  logic [1:0] memDpData;
  int mismatches = 0;
  int n_tests = 0;
  int a, i, s;

  // Block with memory, and the variant without it.
  logic_block #(.RAM_CAPABLE(1'b1)) logic_block_inst (
    .sys_clk, .rst_n, .sliceMode, .rippleFn, .lutTable, .regCfg, .wideSel, .memInitLoad,
    .memInit, .sliceIn, .topIn, .carryIn, .rdAddr, .sliceOut, .topOut, .carryOut,
    .memRdData, .memDpData);
  logic_block #(.RAM_CAPABLE(1'b0)) logic_block_inst2 (
    .sys_clk, .rst_n, .sliceMode, .rippleFn, .lutTable, .regCfg, .wideSel, .memInitLoad,
    .memInit, .sliceIn, .topIn, .carryIn, .rdAddr, .sliceOut(), .topOut(), .carryOut(),
    .memRdData(memRdData2), .memDpData());

  initial forever #2.5 sys_clk = ~sys_clk;

  // Compares one value and counts it.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Waits a fixed number of falling edges.
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step

  // Prints the verdict and ends the run.
  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Word held at one address after the initial load.
  function automatic logic [3:0] initw(input int adr);
    return {memInit[3][adr], memInit[2][adr], memInit[1][adr], memInit[0][adr]};
  endfunction : initw

  // One write cycle; write enable stays up for back-to-back calls.
  task automatic mem_write(input logic [3:0] adr, input logic [3:0] dat);
    sliceIn[2] <= 13'h0800 | 13'(adr);
    sliceIn[0] <= 13'(dat[1:0]) << 8;
    sliceIn[1] <= 13'(dat[3:2]) << 8;
    step(1);
  endtask : mem_write

  // Reads both ports at one address; this also drops write enable.
  task automatic mem_read(input logic [3:0] adr, input logic [3:0] exp);
    sliceIn[2] <= 13'(adr);
    rdAddr <= adr;
    step(2);
    check(16'(memRdData), 16'(exp));
    check(16'(memDpData), 16'(exp[1:0]));
  endtask : mem_read

  // A hung run counts as a failure.
  initial begin
    #100us;
    mismatches++;
    report_and_stop();
  end

  initial begin
    for (i = 0; i < 4; i++) sliceMode[i] = MODE_LOGIC;
    for (i = 0; i < 3; i++) begin
      rippleFn[i] = RIP_ADD;
      regCfg[i] = 5'h00;
      sliceIn[i] = 13'h0000;
    end
    for (i = 0; i < 8; i++) lutTable[i] = 16'h0000;
    wideSel[0] = 1'b0;
    wideSel[1] = 1'b0;
    memInitLoad = 1'b0;
    memInit[0] = 16'haaaa;
    memInit[1] = 16'hcccc;
    memInit[2] = 16'hf0f0;
    memInit[3] = 16'h0000;
    topIn = 10'h000;
    carryIn = 1'b0;
    rdAddr = 4'h0;
    step(3);
    check(16'(topOut), 16'h0000);
    rst_n <= 1'b1;
    // Constant tables give constant outputs, wide ones included.
    for (i = 0; i < 2; i++) begin
      for (s = 0; s < 8; s++) lutTable[s] <= {16{i[0]}};
      step(3);
      check(16'(topOut), 16'({4{i[0]}}));
      for (s = 0; s < 3; s++) check(16'(sliceOut[s][1:0]), 16'({2{i[0]}}));
    end
    // Set/reset loads the configured value in every clocking mode.
    for (s = 0; s < 8; s++) lutTable[s] <= 16'h0000;
    for (i = 0; i < 8; i++) begin
      for (s = 0; s < 3; s++) begin
        regCfg[s] <= {i[2], ~i[2], i[1], i[0] & i[2], i[0]};
        sliceIn[s] <= 13'h1000;
      end
      step(4);
      for (s = 0; s < 3; s++) check(16'(sliceOut[s][3:2]), 16'({i[2], ~i[2]}));
    end
    // Registers capture the table output once selected.
    for (s = 0; s < 8; s++) lutTable[s] <= 16'hffff;
    for (s = 0; s < 3; s++) begin
      regCfg[s] <= 5'h00;
      sliceIn[s] <= 13'h0800;
    end
    step(4);
    for (s = 0; s < 3; s++) check(16'(sliceOut[s][3:2]), 16'h0003);
    // Memory: initial load, read back, back-to-back writes.
    for (i = 0; i < 3; i++) begin
      sliceMode[i] <= MODE_RAM;
      sliceIn[i] <= 13'h0000;
    end
    memInitLoad <= 1'b1;
    step(3);
    memInitLoad <= 1'b0;
    for (a = 0; a < 16; a++) mem_read(a[3:0], initw(a));
    for (a = 0; a < 16; a++) mem_write(a[3:0], ~initw(a));
    for (a = 0; a < 16; a++) begin
      mem_read(a[3:0], ~initw(a));
      check(16'(memRdData2), 16'h000f);
    end
    report_and_stop();
  end
endmodule : programmable_logic_slice_block_test
`default_nettype wire
